/* design/acc_pkg.sv */
// package for the analog comparator control block
// assumes an axi4-lite master with 32-bit data and one word per register
package acc_pkg;
   // ==========================================================
   // register byte offsets
   localparam logic [7:0] ADDR_CMP1_CTRL = 8'h00;
   localparam logic [7:0] ADDR_CMP2_CTRL = 8'h04;
   localparam logic [7:0] ADDR_CMP3_CTRL = 8'h08;
   localparam logic [7:0] ADDR_VREF_CTRL = 8'h0c;
   localparam logic [7:0] ADDR_OUTPUTS = 8'h10;
   localparam logic [7:0] ADDR_IRQ_FLAGS = 8'h14;
   localparam logic [7:0] ADDR_IRQ_ENABLES = 8'h18;
   localparam logic [7:0] ADDR_IRQ_PRIORITY = 8'h1c;
   localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h20;
   // ==========================================================
   // comparator control fields
   localparam int CTL_ON = 7;
   localparam int CTL_PIN_EN = 6;
   localparam int CTL_INVERT = 5;
   localparam int CTL_EDGE_HI = 4;
   localparam int CTL_EDGE_LO = 3;
   localparam int CTL_REF_SEL = 2;
   // voltage reference fields
   localparam int VREF_ON = 7;
   localparam int VREF_PIN_EN = 6;
   localparam int VREF_SRC = 5;
   // status and flag positions
   localparam int OUT_LSB = 5;
   localparam int FLAG_EEPROM = 4;
   // ==========================================================
   // reset values
   localparam logic [7:0] RST_CTRL = 8'h00;
   localparam logic [7:0] RST_VREF = 8'h00;
   localparam logic [7:0] RST_IRQ = 8'h00;
   // event polarity and bus response encodings
   localparam logic [1:0] EDGE_NONE = 2'h0;
   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [1:0] EDGE_FALL = 2'h2;
   localparam logic [1:0] EDGE_BOTH = 2'h3;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : acc_pkg

/* design/acc_top.sv */
// comparator control and status registers on an axi4-lite slave
// assumes the analog cores give a raw result, high when positive > negative
// assumes SLEEPING and EEPROM_EVENT are synchronous to CLK
//
// Summary of operation
// R1 - result reads low when positive input is below negative input
// R2 - result reads high when positive input is above negative input
// R3 - enabled comparators and their interrupts keep working in sleep
// R4 - enabled comparator interrupt during sleep raises wake request
// R5 - software clears comparator_on before sleep to switch comparator off
// R6 - sleep and wake leave every control register untouched
// R7 - reset returns control registers to off values
// R8 - control: on, pin enable, invert, edge select, ref select, channel
// R9 - status bits 7..5 hold results of comparators three, two, one
// R10 - flags in bits 2..0, eeprom flag in bit 4
// R11 - enable bits 2..0 follow flag ordering
// R12 - priority bits 2..0 follow flag ordering
// R13 - reference: on, pin enable, source select, five-bit level
// R14 - unimplemented bits read zero
// R15 - flag sets on selected edge of result, sticky until cleared
// R16 - invert bit flips result for status and output pin
// R17 - interrupt request only while flag and enable both set
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ns
module acc_top
   import acc_pkg::*;
(
   input wire logic CLK,
   input wire logic NRST,
   input wire logic [7:0] AWADDR,
   input wire logic AWVALID,
   output logic AWREADY,
   input wire logic [31:0] WDATA,
   input wire logic [3:0] WSTRB,
   input wire logic WVALID,
   output logic WREADY,
   output logic [1:0] BRESP,
   output logic BVALID,
   input wire logic BREADY,
   input wire logic [7:0] ARADDR,
   input wire logic ARVALID,
   output logic ARREADY,
   output logic [31:0] RDATA,
   output logic [1:0] RRESP,
   output logic RVALID,
   input wire logic RREADY,
   input wire logic [2:0] RAW_RESULT,
   input wire logic EEPROM_EVENT,
   input wire logic SLEEPING,
   output logic [2:0] COMP_ON,
   output logic [2:0] REF_SEL,
   output logic [5:0] CHANNEL_SEL,
   output logic [2:0] RESULT_PIN,
   output logic [2:0] RESULT_PIN_OE,
   output logic REF_ON,
   output logic REF_PIN_EN,
   output logic REF_SRC_SEL,
   output logic [4:0] REF_LEVEL,
   output logic [2:0] IRQ_PRIORITY,
   output logic IRQ,
   output logic WAKE
);
   // ==========================================================
   // state
   logic [7:0] ctrl [3];
   logic [7:0] next_ctrl [3];
   logic [7:0] vref, next_vref;
   logic [2:0] flag, next_flag;
   logic eeprom_flag, next_eeprom_flag;
   logic [2:0] ien, next_ien;
   logic eeprom_ien, next_eeprom_ien;
   logic [2:0] prio, next_prio;
   logic eeprom_prio, next_eeprom_prio;
   logic [2:0] result, next_result;
   logic [2:0] prev_result;
   logic [2:0] next_prev_result;
   logic result_valid, next_result_valid;
   logic aw_held, next_aw_held, w_held, next_w_held;
   logic [7:0] aw_addr, next_aw_addr;
   logic [31:0] w_data, next_w_data;
   logic [3:0] w_strb, next_w_strb;
   logic bvalid, next_bvalid;
   logic [1:0] bresp, next_bresp;
   logic rvalid, next_rvalid;
   logic [1:0] rresp, next_rresp;
   logic [31:0] rdata, next_rdata;
   logic do_write;
   logic [2:0] edge_hit;

   // ==========================================================
   // helpers
   // the clear register counts as mapped, so writes to it answer OKAY
   function automatic logic mapped(input logic [7:0] a);
      mapped = (a == ADDR_CMP1_CTRL) || (a == ADDR_CMP2_CTRL) ||
               (a == ADDR_CMP3_CTRL) || (a == ADDR_VREF_CTRL) ||
               (a == ADDR_OUTPUTS) || (a == ADDR_IRQ_FLAGS) ||
               (a == ADDR_IRQ_ENABLES) || (a == ADDR_IRQ_PRIORITY) ||
               (a == ADDR_IRQ_CLEAR);
   endfunction : mapped

   // edges are looked for on the reported result, after inversion,
   // so the invert bit also flips which edge a rise select catches
   function automatic logic edge_seen(input logic [1:0] sel,
                                      input logic prev, input logic cur);
      unique case (sel)
         EDGE_NONE: edge_seen = 1'b0;
         EDGE_RISE: edge_seen = !prev && cur;
         EDGE_FALL: edge_seen = prev && !cur;
         EDGE_BOTH: edge_seen = prev != cur;
      endcase
   endfunction : edge_seen

   // ==========================================================
   // comparator result path
   // result keeps running regardless of SLEEPING; only comparator_on gates it
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         // raw high means positive above negative, low means below
         next_result[i] = ctrl[i][CTL_ON] &&
                          (RAW_RESULT[i] ^ ctrl[i][CTL_INVERT]); // R1 R2 R16
      end
      next_result_valid = 1'b1;
      next_prev_result = result;
   end

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         result <= 3'h0;
         prev_result <= 3'h0;
         result_valid <= 1'b0;
      end else begin
         result <= next_result;
         prev_result <= next_prev_result;
         result_valid <= next_result_valid;
      end
   end

   always_comb begin
      for (int i = 0; i < 3; i++) begin
         // edge on the reported result, never at the first cycle after reset
         // prev_result resets to zero, the level an off comparator shows
         edge_hit[i] = result_valid && ctrl[i][CTL_ON] &&
                       edge_seen(ctrl[i][CTL_EDGE_HI:CTL_EDGE_LO],
                                 prev_result[i], result[i]); // R15 R3
      end
   end

   // ==========================================================
   // axi write channel
   // address and data may come in either order; each is parked until the
   // other arrives, and nothing new is taken while a response stands
   assign do_write = aw_held && w_held && !bvalid;

   always_comb begin
      next_aw_held = aw_held;
      next_aw_addr = aw_addr;
      next_w_held = w_held;
      next_w_data = w_data;
      next_w_strb = w_strb;
      next_bvalid = bvalid;
      next_bresp = bresp;
      if (AWVALID && AWREADY) begin
         next_aw_held = 1'b1;
         next_aw_addr = AWADDR;
      end
      if (WVALID && WREADY) begin
         next_w_held = 1'b1;
         next_w_data = WDATA;
         next_w_strb = WSTRB;
      end
      if (do_write) begin
         next_aw_held = 1'b0;
         next_w_held = 1'b0;
         next_bvalid = 1'b1;
         next_bresp = mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid && BREADY) begin
         next_bvalid = 1'b0;
      end
   end

   // ==========================================================
   // register file; SLEEPING never touches it
   // so a wake always finds the control registers as software left them
   always_comb begin
      next_ctrl = ctrl; // R6
      next_vref = vref;
      next_ien = ien;
      next_eeprom_ien = eeprom_ien;
      next_prio = prio;
      next_eeprom_prio = eeprom_prio;
      next_flag = flag;
      next_eeprom_flag = eeprom_flag;
      // only the low byte lane carries register bits
      if (do_write && w_strb[0]) begin
         unique case (aw_addr)
            ADDR_CMP1_CTRL: next_ctrl[0] = w_data[7:0]; // R8
            ADDR_CMP2_CTRL: next_ctrl[1] = w_data[7:0]; // R8
            ADDR_CMP3_CTRL: next_ctrl[2] = w_data[7:0]; // R8
            ADDR_VREF_CTRL: next_vref = w_data[7:0]; // R13
            ADDR_IRQ_ENABLES: begin
               next_ien = w_data[2:0]; // R11
               next_eeprom_ien = w_data[FLAG_EEPROM];
            end
            ADDR_IRQ_PRIORITY: begin
               next_prio = w_data[2:0]; // R12
               next_eeprom_prio = w_data[FLAG_EEPROM];
            end
            // write-one-to-clear, so clearing one flag cannot lose another
            ADDR_IRQ_CLEAR: begin
               next_flag = flag & ~w_data[2:0];
               next_eeprom_flag = eeprom_flag & !w_data[FLAG_EEPROM];
            end
            default: ;
         endcase
      end
      // set after clear so an event in the clearing cycle survives
      next_flag = next_flag | edge_hit; // R15
      next_eeprom_flag = next_eeprom_flag | EEPROM_EVENT; // R10
   end

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         // off values: every comparator and the reference switched off
         for (int i = 0; i < 3; i++) begin
            ctrl[i] <= RST_CTRL; // R7
         end
         vref <= RST_VREF; // R7
         flag <= RST_IRQ[2:0];
         eeprom_flag <= 1'b0;
         ien <= RST_IRQ[2:0];
         eeprom_ien <= 1'b0;
         prio <= RST_IRQ[2:0];
         eeprom_prio <= 1'b0;
         aw_held <= 1'b0;
         aw_addr <= 8'h00;
         w_held <= 1'b0;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
      end else begin
         ctrl <= next_ctrl;
         vref <= next_vref;
         flag <= next_flag;
         eeprom_flag <= next_eeprom_flag;
         ien <= next_ien;
         eeprom_ien <= next_eeprom_ien;
         prio <= next_prio;
         eeprom_prio <= next_eeprom_prio;
         aw_held <= next_aw_held;
         aw_addr <= next_aw_addr;
         w_held <= next_w_held;
         w_data <= next_w_data;
         w_strb <= next_w_strb;
         bvalid <= next_bvalid;
         bresp <= next_bresp;
      end
   end

   // ==========================================================
   // axi read channel, one cycle after the address is taken
   // ARREADY is low while an answer stands, so back-to-back reads lose
   // one idle cycle each; traded for a single read data register
   always_comb begin
      next_rvalid = rvalid;
      next_rresp = rresp;
      next_rdata = rdata;
      if (ARVALID && ARREADY) begin
         next_rvalid = 1'b1;
         next_rresp = mapped(ARADDR) ? RESP_OKAY : RESP_SLVERR;
         next_rdata = 32'h0000_0000; // R14
         unique case (ARADDR)
            ADDR_CMP1_CTRL: next_rdata[7:0] = ctrl[0];
            ADDR_CMP2_CTRL: next_rdata[7:0] = ctrl[1];
            ADDR_CMP3_CTRL: next_rdata[7:0] = ctrl[2];
            ADDR_VREF_CTRL: next_rdata[7:0] = vref;
            ADDR_OUTPUTS: next_rdata[7:OUT_LSB] =
               {result[2], result[1], result[0]}; // R9 R14
            ADDR_IRQ_FLAGS: begin
               next_rdata[2:0] = flag; // R10
               next_rdata[FLAG_EEPROM] = eeprom_flag;
            end
            ADDR_IRQ_ENABLES: begin
               next_rdata[2:0] = ien; // R11
               next_rdata[FLAG_EEPROM] = eeprom_ien;
            end
            ADDR_IRQ_PRIORITY: begin
               next_rdata[2:0] = prio; // R12
               next_rdata[FLAG_EEPROM] = eeprom_prio;
            end
            default: ; // clear register and holes read zero
         endcase
      end else if (rvalid && RREADY) begin
         next_rvalid = 1'b0;
      end
   end

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         rvalid <= 1'b0;
         rresp <= RESP_OKAY;
         rdata <= 32'h0000_0000;
      end else begin
         rvalid <= next_rvalid;
         rresp <= next_rresp;
         rdata <= next_rdata;
      end
   end

   // ==========================================================
   // outputs
   assign AWREADY = !aw_held && !bvalid;
   assign WREADY = !w_held && !bvalid;
   assign BVALID = bvalid;
   assign BRESP = bresp;
   assign ARREADY = !rvalid;
   assign RVALID = rvalid;
   assign RRESP = rresp;
   assign RDATA = rdata;

   always_comb begin
      for (int i = 0; i < 3; i++) begin
         COMP_ON[i] = ctrl[i][CTL_ON];
         REF_SEL[i] = ctrl[i][CTL_REF_SEL];
         CHANNEL_SEL[2*i +: 2] = ctrl[i][1:0];
         // the pin is driven only while the comparator is on, so a core
         // that is switched off never fights whatever else owns the pad
         RESULT_PIN_OE[i] = ctrl[i][CTL_ON] && ctrl[i][CTL_PIN_EN];
      end
   end
   assign RESULT_PIN = result; // R16
   assign REF_ON = vref[VREF_ON];
   assign REF_PIN_EN = vref[VREF_PIN_EN];
   assign REF_SRC_SEL = vref[VREF_SRC];
   assign REF_LEVEL = vref[4:0];
   assign IRQ_PRIORITY = prio;
   // the eeprom flag shares the register but not this request line
   assign IRQ = |(flag & ien); // R17
   // wake is the same request, qualified by sleep
   // a flag left pending before sleep therefore wakes the core at once
   assign WAKE = SLEEPING && |(flag & ien); // R4 R3
endmodule : acc_top

/* bench/acc_analog_model.sv */
// behavioural analog cores of the three comparators
// levels are 8-bit codes standing for input voltages, comparator 1 lowest
`timescale 1ns/1ns
module acc_analog_model (
   input wire logic [23:0] pos_level,
   input wire logic [23:0] neg_level,
   output logic [2:0] raw_result
);
   // equal levels read low; a real core is uncertain there anyway
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         raw_result[i] = pos_level[8*i +: 8] > neg_level[8*i +: 8];
      end
   end
endmodule : acc_analog_model

/* bench/acc_top_monitor.sv */
// port checker for acc_top
// bound to every acc_top instance, one clock domain
`timescale 1ns/1ns
module acc_top_monitor (
   input wire logic CLK,
   input wire logic NRST,
   input wire logic AWVALID,
   input wire logic AWREADY,
   input wire logic WVALID,
   input wire logic WREADY,
   input wire logic BVALID,
   input wire logic ARVALID,
   input wire logic ARREADY,
   input wire logic [31:0] RDATA,
   input wire logic RVALID,
   input wire logic RREADY,
   input wire logic SLEEPING,
   input wire logic [2:0] COMP_ON,
   input wire logic [5:0] CHANNEL_SEL,
   input wire logic [2:0] RESULT_PIN,
   input wire logic [2:0] RESULT_PIN_OE,
   input wire logic IRQ,
   input wire logic WAKE
);
   default clocking @(posedge CLK); endclocking
   default disable iff (!NRST);
   // a write lands one edge after its last valid, so two quiet cycles
   sequence bus_quiet;
      (!AWVALID && !WVALID)[*2];
   endsequence
   a_wake_follows: assert property (WAKE == (SLEEPING && IRQ))
      else $error("wake not tied to sleep and irq");
   a_pin_oe_on: assert property ((RESULT_PIN_OE & ~COMP_ON) == 3'h0)
      else $error("pin enabled on a switched-off comparator");
   a_off_pin_low: assert property (
      (RESULT_PIN & ~COMP_ON & ~$past(COMP_ON)) == 3'h0)
      else $error("result high on a switched-off comparator");
   a_sleep_holds: assert property (
      bus_quiet ##0 $changed(SLEEPING) |=> $stable(COMP_ON)
      && $stable(CHANNEL_SEL))
      else $error("sleep change altered control");
   a_high_bits_zero: assert property (RVALID |-> RDATA[31:8] == 24'h0)
      else $error("read data upper bits not zero");
   a_write_blocks: assert property (BVALID |-> !AWREADY && !WREADY)
      else $error("write accepted while response pending");
   a_read_answer: assert property (ARVALID && ARREADY |=> RVALID)
      else $error("read answer late");
   a_read_holds: assert property (
      RVALID && !RREADY |=> RVALID && $stable(RDATA))
      else $error("read data dropped before taken");
endmodule : acc_top_monitor
bind acc_top acc_top_monitor u_acc_top_monitor (.CLK(CLK), .NRST(NRST),
   .AWVALID(AWVALID), .AWREADY(AWREADY), .WVALID(WVALID),
   .WREADY(WREADY), .BVALID(BVALID), .ARVALID(ARVALID),
   .ARREADY(ARREADY), .RDATA(RDATA), .RVALID(RVALID), .RREADY(RREADY),
   .SLEEPING(SLEEPING), .COMP_ON(COMP_ON), .CHANNEL_SEL(CHANNEL_SEL),
   .RESULT_PIN(RESULT_PIN), .RESULT_PIN_OE(RESULT_PIN_OE), .IRQ(IRQ),
   .WAKE(WAKE));

/* bench/acc_top_test.sv */
// self-checking bench for acc_top
// drives the register bus and the analog model, single clock
`timescale 1ns/1ns
module acc_top_test;
   import acc_pkg::*;
   typedef struct {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic [31:0] rexp;
   } acc_row_s;
   logic CLK, NRST, AWVALID, WVALID, BREADY, ARVALID, RREADY;
   logic AWREADY, WREADY, BVALID, ARREADY, RVALID, IRQ, WAKE;
   logic EEPROM_EVENT, SLEEPING, REF_ON, REF_PIN_EN, REF_SRC_SEL;
   logic [7:0] AWADDR, ARADDR;
   logic [31:0] WDATA, RDATA, rdat;
   logic [3:0] WSTRB;
   logic [1:0] BRESP, RRESP, resp;
   logic [2:0] RAW_RESULT, COMP_ON, REF_SEL, RESULT_PIN, RESULT_PIN_OE;
   logic [2:0] IRQ_PRIORITY;
   logic [5:0] CHANNEL_SEL;
   logic [4:0] REF_LEVEL;
   logic [23:0] pos_level, neg_level;
   int mismatches = 0;
   int compares = 0;
   acc_row_s rows [7] = '{
      '{ADDR_CMP1_CTRL, 32'hffffffff, 32'hff},
      '{ADDR_CMP2_CTRL, 32'h5a, 32'h5a},
      '{ADDR_CMP3_CTRL, 32'ha5, 32'ha5},
      '{ADDR_VREF_CTRL, 32'hff, 32'hff},
      '{ADDR_IRQ_ENABLES, 32'hff, 32'h17},
      '{ADDR_IRQ_PRIORITY, 32'hff, 32'h17},
      '{ADDR_IRQ_CLEAR, 32'h00, 32'h00}};
   acc_top u_acc_top (.CLK(CLK), .NRST(NRST), .AWADDR(AWADDR),
      .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB),
      .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID),
      .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
      .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
      .RREADY(RREADY), .RAW_RESULT(RAW_RESULT),
      .EEPROM_EVENT(EEPROM_EVENT), .SLEEPING(SLEEPING), .COMP_ON(COMP_ON),
      .REF_SEL(REF_SEL), .CHANNEL_SEL(CHANNEL_SEL),
      .RESULT_PIN(RESULT_PIN), .RESULT_PIN_OE(RESULT_PIN_OE),
      .REF_ON(REF_ON), .REF_PIN_EN(REF_PIN_EN), .REF_SRC_SEL(REF_SRC_SEL),
      .REF_LEVEL(REF_LEVEL), .IRQ_PRIORITY(IRQ_PRIORITY), .IRQ(IRQ),
      .WAKE(WAKE));
   acc_analog_model u_acc_analog_model (.pos_level(pos_level),
      .neg_level(neg_level), .raw_result(RAW_RESULT));
   initial begin
      CLK = 1'b0;
      forever #10 CLK = ~CLK;
   end
   // ==========================================================
   // bus tasks
   task automatic finish_test;
      if (mismatches == 0 && compares > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : finish_test
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic guard(inout int n);
      n++;
      if (n > 100) begin
         mismatches++;
         $display("MISMATCH %0t bus wait ran out", $time);
         finish_test();
      end
   endtask : guard
   // readies and answers are taken at the rising edge that completes them
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic pa, pw, done;
      int n;
      pa = 1'b1;
      pw = 1'b1;
      done = 1'b0;
      n = 0;
      @(posedge CLK);
      AWADDR <= a;
      AWVALID <= 1'b1;
      WDATA <= d;
      WVALID <= 1'b1;
      BREADY <= 1'b1;
      while (!done) begin
         @(posedge CLK);
         pa = pa && !AWREADY;
         pw = pw && !WREADY;
         done = BVALID;
         resp = BRESP;
         AWVALID <= pa;
         WVALID <= pw;
         guard(n);
      end
      BREADY <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      logic pa, done;
      int n;
      pa = 1'b1;
      done = 1'b0;
      n = 0;
      @(posedge CLK);
      ARADDR <= a;
      ARVALID <= 1'b1;
      RREADY <= 1'b1;
      while (!done) begin
         @(posedge CLK);
         pa = pa && !ARREADY;
         done = RVALID;
         rdat = RDATA;
         resp = RRESP;
         ARVALID <= pa;
         guard(n);
      end
      RREADY <= 1'b0;
   endtask : rd
   task automatic rc(input logic [7:0] a, input logic [31:0] exp);
      rd(a);
      check(rdat, exp);
   endtask : rc
   task automatic settle;
      // result lands one edge after the input, the flag one edge later
      repeat (3) @(posedge CLK);
   endtask : settle
   // ==========================================================
   // main sequence
   initial begin
      NRST = 1'b0;
      AWADDR = 8'h00;
      ARADDR = 8'h00;
      AWVALID = 1'b0;
      WVALID = 1'b0;
      ARVALID = 1'b0;
      BREADY = 1'b0;
      RREADY = 1'b0;
      WDATA = 32'h0;
      WSTRB = 4'hf;
      EEPROM_EVENT = 1'b0;
      SLEEPING = 1'b0;
      pos_level = 24'h0;
      neg_level = 24'h808080;
      repeat (12) @(posedge CLK);
      NRST <= 1'b1;
      foreach (rows[i]) rc(rows[i].addr, 32'h0);
      rc(ADDR_IRQ_FLAGS, 32'h0);
      foreach (rows[i]) begin
         wr(rows[i].addr, rows[i].wdata);
         rc(rows[i].addr, rows[i].rexp);
      end
      check({6'h0, COMP_ON, REF_SEL, CHANNEL_SEL, RESULT_PIN_OE, REF_ON,
         REF_PIN_EN, REF_SRC_SEL, REF_LEVEL, IRQ_PRIORITY},
         {6'h0, 3'h5, 3'h5, 6'h1b, 3'h1, 3'h7, 5'h1f, 3'h7});
      rc(ADDR_OUTPUTS, 32'ha0);
      check({29'h0, RESULT_PIN}, 32'h5);
      rc(ADDR_IRQ_FLAGS, 32'h01);
      check({31'h0, IRQ}, 32'h1);
      wr(8'h40, 32'hff);
      check({30'h0, resp}, {30'h0, RESP_SLVERR});
      rd(8'h40);
      check({30'h0, resp}, {30'h0, RESP_SLVERR});
      WSTRB <= 4'he;
      wr(ADDR_CMP2_CTRL, 32'h00);
      WSTRB <= 4'hf;
      rc(ADDR_CMP2_CTRL, 32'h5a);
      wr(ADDR_IRQ_CLEAR, 32'h07);
      check({31'h0, IRQ}, 32'h0);
      wr(ADDR_CMP1_CTRL, 32'h88);
      rc(ADDR_IRQ_FLAGS, 32'h0);
      pos_level <= 24'h0000ff;
      settle();
      rc(ADDR_OUTPUTS, 32'ha0);
      rc(ADDR_IRQ_FLAGS, 32'h01);
      wr(ADDR_IRQ_ENABLES, 32'h0);
      check({31'h0, IRQ}, 32'h0);
      pos_level <= 24'h0;
      settle();
      rc(ADDR_OUTPUTS, 32'h80);
      wr(ADDR_IRQ_CLEAR, 32'h07);
      wr(ADDR_IRQ_ENABLES, 32'h01);
      SLEEPING <= 1'b1;
      pos_level <= 24'h0000ff;
      settle();
      check({30'h0, IRQ, WAKE}, 32'h3);
      SLEEPING <= 1'b0;
      rc(ADDR_CMP1_CTRL, 32'h88);
      EEPROM_EVENT <= 1'b1;
      @(posedge CLK);
      EEPROM_EVENT <= 1'b0;
      rc(ADDR_IRQ_FLAGS, 32'h11);
      wr(ADDR_IRQ_CLEAR, 32'h17);
      wr(ADDR_CMP1_CTRL, 32'h10);
      SLEEPING <= 1'b1;
      pos_level <= 24'h0;
      settle();
      check({30'h0, IRQ, WAKE}, 32'h0);
      rc(ADDR_OUTPUTS, 32'h80);
      wr(ADDR_CMP1_CTRL, 32'h90);
      pos_level <= 24'h0000ff;
      settle();
      rc(ADDR_IRQ_FLAGS, 32'h0);
      pos_level <= 24'h0;
      settle();
      check({30'h0, IRQ, WAKE}, 32'h3);
      SLEEPING <= 1'b0;
      NRST <= 1'b0;
      repeat (2) @(posedge CLK);
      NRST <= 1'b1;
      rc(ADDR_CMP1_CTRL, 32'h0);
      check({28'h0, COMP_ON, REF_ON}, 32'h0);
      finish_test();
   end
endmodule : acc_top_test
